// ==== design/cise_pkg.sv ====
/*
 * Constants, types and register map of the instruction executor.
 * Assumes a single 25 MHz core clock and an APB master with 8-bit byte addresses.
 */
package cise_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_INSTR  = 8'h00;
	localparam logic [7:0] OFS_WREG   = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_PCHI   = 8'h0c;
	localparam logic [7:0] OFS_PC     = 8'h10;
	localparam logic [7:0] OFS_FADDR  = 8'h14;
	localparam logic [7:0] OFS_FDATA  = 8'h18;

	localparam int STAT_C = 0;
	localparam int STAT_Z = 1;

	// ------------------------------------------------------------
	// Instruction word fields
	// ------------------------------------------------------------
	localparam int IW_W       = 14;
	localparam int OPC_LSB    = 11;
	localparam int DEST_BIT   = 7;
	localparam int FA_W       = 7;
	localparam int LIT_W      = 8;
	localparam int BR_W       = 11;
	localparam int PC_W       = 15;
	localparam int PCL_W      = 7;
	localparam int PCL_LO     = 3;
	localparam int NUM_FILE   = 128;

	localparam logic [2:0] OP_NONE    = 3'h0;
	localparam logic [2:0] OP_INCSKIP = 3'h1;
	localparam logic [2:0] OP_INC     = 3'h2;
	localparam logic [2:0] OP_ORLIT   = 3'h3;
	localparam logic [2:0] OP_ORFILE  = 3'h4;
	localparam logic [2:0] OP_LSL     = 3'h5;
	localparam logic [2:0] OP_BRANCH  = 3'h6;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_EXEC   = 3'b010,
		ST_SECOND = 3'b100
	} cise_state_e;

	typedef struct packed {
		cise_state_e                   st;
		logic [IW_W-1:0]               ir;
		logic [7:0]                    wreg;
		logic                          c;
		logic                          z;
		logic [PCL_W-1:0]              pc_hi;
		logic [PC_W-1:0]               pc;
		logic [FA_W-1:0]               faddr;
		logic [NUM_FILE-1:0][7:0]      file;
		logic                          pready;
		logic [31:0]                   prdata;
		logic                          pslverr;
		logic                          busy;
	} cise_regs_s;

endpackage

// ==== design/cise_alu.sv ====
/*
 * Combinational datapath for the increment, OR and left shift operations.
 * Assumes the caller supplies the accumulator, the addressed file value and the word.
 */
`timescale 1ns/1ps
`default_nettype none

module cise_alu
	import cise_pkg::*;
(
	input  wire logic [2:0]      i_op,
	input  wire logic [IW_W-1:0] i_ir,
	input  wire logic [7:0]      i_wreg,
	input  wire logic [7:0]      i_fval,
	output logic      [7:0]      o_res,
	output logic                 o_wr,
	output logic                 o_to_file,
	output logic                 o_upd_z,
	output logic                 o_upd_c,
	output logic                 o_carry,
	output logic                 o_skip
);

	logic d_sel;

	assign d_sel = i_ir[DEST_BIT];

	always_comb begin
		o_res     = 8'h00;
		o_wr      = 1'b0;
		o_to_file = 1'b0;
		o_upd_z   = 1'b0;
		o_upd_c   = 1'b0;
		o_carry   = 1'b0;
		o_skip    = 1'b0;
		case (i_op)
			// increment, skip on zero, flags kept.
			OP_INCSKIP: begin
				o_res     = i_fval + 8'h01;
				o_wr      = 1'b1;
				o_to_file = d_sel;
				o_skip    = (o_res == 8'h00);
			end
			OP_INC: begin
				o_res     = i_fval + 8'h01;
				o_wr      = 1'b1;
				o_to_file = d_sel;
				o_upd_z   = 1'b1;
			end
			OP_ORLIT: begin
				o_res   = i_wreg | i_ir[LIT_W-1:0];
				o_wr    = 1'b1;
				o_upd_z = 1'b1;
			end
			OP_ORFILE: begin
				o_res     = i_wreg | i_fval;
				o_wr      = 1'b1;
				o_to_file = d_sel;
				o_upd_z   = 1'b1;
			end
			OP_LSL: begin
				o_res     = {i_fval[6:0], 1'b0};
				o_carry   = i_fval[7];
				o_wr      = 1'b1;
				o_to_file = d_sel;
				o_upd_z   = 1'b1;
				o_upd_c   = 1'b1;
			end
			default: begin
				o_res = 8'h00;
			end
		endcase
	end

endmodule

`default_nettype wire

// ==== design/cise_exec.sv ====
/*
 * Executor for increment, increment-skip, OR, left shift and branch, with APB registers.
 * Assumes an APB master on the same clock; file registers live inside this block.
 */
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module cise_exec
	import cise_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_nrst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_busy
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == OFS_INSTR) || (a == OFS_WREG) || (a == OFS_STATUS) ||
			(a == OFS_PCHI) || (a == OFS_PC) || (a == OFS_FADDR) || (a == OFS_FDATA);
	endfunction

	function automatic logic [31:0] rd_word(input logic [7:0] a, input cise_regs_s r);
		rd_word = 32'h0000_0000;
		case (a)
			OFS_INSTR:  rd_word[IW_W-1:0]  = r.ir;
			OFS_WREG:   rd_word[7:0]       = r.wreg;
			OFS_STATUS: rd_word[1:0]       = {r.z, r.c};
			OFS_PCHI:   rd_word[PCL_W-1:0] = r.pc_hi;
			OFS_PC:     rd_word[PC_W-1:0]  = r.pc;
			OFS_FADDR:  rd_word[FA_W-1:0]  = r.faddr;
			OFS_FDATA:  rd_word[7:0]       = r.file[r.faddr];
			default:    rd_word            = 32'h0000_0000;
		endcase
	endfunction

	cise_regs_s       s_r;
	cise_regs_s       s_nxt;
	logic             acc;
	logic [2:0]       op;
	logic [FA_W-1:0]  ir_fa;
	logic [7:0]       fval;
	logic [7:0]       res;
	logic             wr;
	logic             to_file;
	logic             upd_z;
	logic             upd_c;
	logic             carry;
	logic             skip;
	logic             res_zero;
	logic             in_exec;

	// opcode and 7-bit file address fields.
	assign op       = s_r.ir[IW_W-1:OPC_LSB];
	assign ir_fa    = s_r.ir[FA_W-1:0];
	assign fval     = s_r.file[ir_fa];
	// zero test on the 8-bit result.
	assign res_zero = (res == 8'h00);
	assign in_exec  = (s_r.st == ST_EXEC);
	assign acc      = i_psel & i_penable & s_r.pready;

	cise_alu u_alu (
		.i_op      (op),
		.i_ir      (s_r.ir),
		.i_wreg    (s_r.wreg),
		.i_fval    (fval),
		.o_res     (res),
		.o_wr      (wr),
		.o_to_file (to_file),
		.o_upd_z   (upd_z),
		.o_upd_c   (upd_c),
		.o_carry   (carry),
		.o_skip    (skip)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// Wait states while an instruction runs keep software from racing the datapath.
		s_nxt.pready  = i_psel & i_penable & ~s_r.pready & (s_r.st == ST_IDLE);
		s_nxt.pslverr = 1'b0;
		if (s_nxt.pready) begin
			s_nxt.prdata  = rd_word(i_paddr, s_r);
			s_nxt.pslverr = ~addr_ok(i_paddr);
		end
		if (acc && i_pwrite) begin
			case (i_paddr)
				OFS_INSTR: begin
					s_nxt.ir = i_pwdata[IW_W-1:0];
					s_nxt.st = ST_EXEC;
				end
				OFS_WREG:   s_nxt.wreg   = i_pwdata[7:0];
				OFS_STATUS: begin
					s_nxt.c = i_pwdata[STAT_C];
					s_nxt.z = i_pwdata[STAT_Z];
				end
				OFS_PCHI:   s_nxt.pc_hi  = i_pwdata[PCL_W-1:0];
				OFS_PC:     s_nxt.pc     = i_pwdata[PC_W-1:0];
				OFS_FADDR:  s_nxt.faddr  = i_pwdata[FA_W-1:0];
				OFS_FDATA:  s_nxt.file[s_r.faddr] = i_pwdata[7:0];
				default:    s_nxt.st     = s_r.st;
			endcase
		end
		case (s_r.st)
			ST_IDLE: begin
				s_nxt.busy = s_nxt.st != ST_IDLE;
			end
			ST_EXEC: begin
				// route result to accumulator or file.
				if (wr && to_file) begin
					s_nxt.file[ir_fa] = res;
				end else if (wr) begin
					s_nxt.wreg = res;
				end
				if (upd_z) begin
					s_nxt.z = res_zero;
				end
				if (upd_c) begin
					s_nxt.c = carry;
				end
				if (op == OP_BRANCH) begin
					// low PC bits from the immediate.
					s_nxt.pc[BR_W-1:0]    = s_r.ir[BR_W-1:0];
					// upper PC bits from latch bits 6:3.
					s_nxt.pc[PC_W-1:BR_W] = s_r.pc_hi[PCL_W-1:PCL_LO];
					s_nxt.st = ST_SECOND;
				end else begin
					s_nxt.pc = s_r.pc + 15'h0001;
					// skip turns the next slot into a no-operation.
					s_nxt.st = skip ? ST_SECOND : ST_IDLE;
				end
				s_nxt.busy = s_nxt.st != ST_IDLE;
			end
			ST_SECOND: begin
				// The discarded slot still advances the PC unless a branch reloaded it.
				if (op != OP_BRANCH) begin
					s_nxt.pc = s_r.pc + 15'h0001;
				end
				s_nxt.st   = ST_IDLE;
				s_nxt.busy = 1'b0;
			end
			default: begin
				s_nxt.st   = ST_IDLE;
				s_nxt.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			s_r <= '{st: ST_IDLE, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_prdata  = s_r.prdata;
	assign o_pready  = s_r.pready;
	assign o_pslverr = s_r.pslverr;
	assign o_busy    = s_r.busy;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	logic [7:0] cur_w;
	logic [7:0] cur_lit;
	assign cur_w   = s_r.wreg;
	assign cur_lit = s_r.ir[LIT_W-1:0];

	sequence seq_two_cycle;
		(s_r.st == ST_SECOND) ##1 (s_r.st == ST_IDLE);
	endsequence

	sequence seq_go(logic [2:0] o);
		in_exec && (op == o);
	endsequence

	a_branch_slots: assert property (seq_go(OP_BRANCH) |=> seq_two_cycle)
		else $error("Branch did not take two cycles.");
	a_branch_target: assert property (seq_go(OP_BRANCH) |=>
		s_r.pc == {$past(s_r.pc_hi[6:3]), $past(s_r.ir[10:0])})
		else $error("Branch target wrong.");
	a_skip_slots: assert property (in_exec && (op == OP_INCSKIP) && res_zero |=> seq_two_cycle)
		else $error("Zero increment-skip did not skip.");
	a_skip_flags: assert property (seq_go(OP_INCSKIP) |=> $stable(s_r.z) && $stable(s_r.c))
		else $error("Increment-skip changed a flag.");
	a_inc_zero: assert property (seq_go(OP_INC) |=> s_r.z == ($past(res) == 8'h00))
		else $error("Increment zero flag wrong.");
	a_inc_wrap: assert property (in_exec && (op == OP_INC) && fval == 8'hff |=> s_r.z)
		else $error("Increment of 0xff did not wrap to zero.");
	a_orlit_acc: assert property (seq_go(OP_ORLIT) |=>
		s_r.wreg == ($past(cur_w) | $past(cur_lit)))
		else $error("Literal OR result wrong.");
	a_orfile_acc: assert property (in_exec && (op == OP_ORFILE) && !s_r.ir[DEST_BIT] |=>
		s_r.wreg == ($past(cur_w) | $past(fval)))
		else $error("File OR result wrong.");
	a_lsl_carry: assert property (seq_go(OP_LSL) |=> s_r.c == $past(fval[7]))
		else $error("Shift carry wrong.");
	a_dest_file: assert property (in_exec && wr && to_file |=>
		s_r.file[$past(ir_fa)] == $past(res) && $stable(s_r.wreg))
		else $error("File destination not written.");
	a_zero_flag: assert property (in_exec && upd_z |=> s_r.z == $past(res_zero))
		else $error("Zero flag mismatch.");

endmodule

`default_nettype wire

// ==== tb/cise_host.sv ====
/*
 * Register bus master that stands in for software driving the executor.
 * Assumes one clock shared with the executor; the bench ends any hung wait.
 */
`timescale 1ns/1ps
`default_nettype none

module cise_host (
	input  wire logic        i_clk_sys,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic      [7:0]  o_paddr,
	output logic      [31:0] o_pwdata,
	input  wire logic [31:0] i_prdata,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr
);
	// ------------------------------------------------------------
	// Bus transfer
	// ------------------------------------------------------------
	initial begin
		o_psel    = 1'b0;
		o_penable = 1'b0;
		o_pwrite  = 1'b0;
		o_paddr   = 8'h00;
		o_pwdata  = 32'h0;
	end

	// The first edge keeps a release and the next setup out of one time step.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic se);
		@(posedge i_clk_sys);
		o_psel    <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite  <= w;
		o_paddr   <= a;
		o_pwdata  <= wd;
		@(posedge i_clk_sys);
		o_penable <= 1'b1;
		do @(posedge i_clk_sys); while (i_pready !== 1'b1);
		rd = i_prdata;
		se = i_pslverr;
		o_psel    <= 1'b0;
		o_penable <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
/*
 * Self-checking bench for the instruction executor.
 * Assumes cise_host carries the bus; results are read back over the bus.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench
	import cise_pkg::*;
;
	logic        clk  = 1'b0;
	logic        nrst = 1'b0;
	logic        psel, pen, pwr, rdy, serr, busy;
	logic [7:0]  addr;
	logic [31:0] wdat, rdat;
	logic [31:0] bcnt = 32'h0;
	logic [31:0] blen = 32'h0;
	logic [31:0] d;
	logic        s;
	int          err_count = 0;
	int          checked   = 0;
	int          cyc       = 0;

	cise_exec dut (.i_clk_sys(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(rdat),
		.o_pready(rdy), .o_pslverr(serr), .o_busy(busy));
	cise_host host (.i_clk_sys(clk), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
		.o_paddr(addr), .o_pwdata(wdat), .i_prdata(rdat), .i_pready(rdy),
		.i_pslverr(serr));

	always #20 clk = ~clk;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// The length of the last busy stretch shows one or two cycle execution.
	always @(posedge clk) begin
		if (busy === 1'b1) begin
			bcnt <= bcnt + 32'h1;
		end else if (bcnt != 32'h0) begin
			blen <= bcnt;
			bcnt <= 32'h0;
		end
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// A few hundred cycles are needed; the ceiling leaves a wide margin.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			report_and_stop();
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		host.xfer(1'b1, a, v, d, s);
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0, d, s);
		cmp({31'h0, s}, 32'h0);
		cmp(d, e);
	endtask

	// Opcode in bits 13:11, operand field in bits 10:0.
	task automatic ex(input logic [2:0] op, input logic [10:0] k);
		wr(OFS_INSTR, {18'h0, op, k});
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	logic [7:0] src [3] = '{8'h81, 8'h80, 8'h40};
	logic [7:0] res [3] = '{8'h02, 8'h00, 8'h80};
	logic [1:0] flg [3] = '{2'h1, 2'h3, 2'h0};

	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		chk(OFS_PC, 32'h0);
		wr(OFS_FADDR, 32'h7f);
		wr(OFS_FDATA, 32'hff);
		ex(OP_INC, 11'h0ff);
		chk(OFS_FDATA, 32'h0);
		chk(OFS_STATUS, 32'h2);
		cmp(blen, 32'h1);
		wr(OFS_FDATA, 32'h41);
		ex(OP_INC, 11'h07f);
		chk(OFS_WREG, 32'h42);
		chk(OFS_FDATA, 32'h41);
		chk(OFS_STATUS, 32'h0);
		wr(OFS_FDATA, 32'hff);
		wr(OFS_STATUS, 32'h1);
		wr(OFS_PC, 32'h100);
		ex(OP_INCSKIP, 11'h07f);
		chk(OFS_WREG, 32'h0);
		chk(OFS_STATUS, 32'h1);
		chk(OFS_PC, 32'h102);
		cmp(blen, 32'h2);
		wr(OFS_FDATA, 32'h10);
		ex(OP_INCSKIP, 11'h0ff);
		chk(OFS_FDATA, 32'h11);
		chk(OFS_PC, 32'h103);
		wr(OFS_WREG, 32'h50);
		ex(OP_ORLIT, 11'h00a);
		chk(OFS_WREG, 32'h5a);
		chk(OFS_STATUS, 32'h1);
		wr(OFS_WREG, 32'h0);
		ex(OP_ORLIT, 11'h000);
		chk(OFS_STATUS, 32'h3);
		wr(OFS_WREG, 32'h0f);
		wr(OFS_FDATA, 32'h30);
		ex(OP_ORFILE, 11'h0ff);
		chk(OFS_FDATA, 32'h3f);
		chk(OFS_WREG, 32'h0f);
		chk(OFS_STATUS, 32'h1);
		ex(OP_ORFILE, 11'h07f);
		chk(OFS_WREG, 32'h3f);
		chk(OFS_FDATA, 32'h3f);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_FDATA, {24'h0, src[i]});
			wr(OFS_STATUS, 32'h0);
			ex(OP_LSL, 11'h07f);
			chk(OFS_WREG, {24'h0, res[i]});
			chk(OFS_STATUS, {30'h0, flg[i]});
		end
		wr(OFS_PCHI, 32'h5a);
		ex(OP_BRANCH, 11'h7ff);
		chk(OFS_PC, 32'h5fff);
		cmp(blen, 32'h2);
		wr(OFS_PCHI, 32'h07);
		ex(OP_BRANCH, 11'h123);
		chk(OFS_PC, 32'h0123);
		// Unassigned opcode seven runs as a one-cycle no-operation.
		ex(3'h7, 11'h000);
		chk(OFS_PC, 32'h0124);
		cmp(blen, 32'h1);
		host.xfer(1'b0, 8'h1c, 32'h0, d, s);
		cmp({s, d[30:0]}, 32'h80000000);
		report_and_stop();
	end
endmodule

`default_nettype wire
